// >>> hdl/dpc_pkg.sv
// Constants and types for the DRAM page controller with bus watchdog.
// Assumes one clock (pclk) shared by CPU bus, APB and DRAM strobes.
// Summary of operation
// - Count external bus cycle clocks; at 1024 force completion by ready.
// - Time-over lights indicator, raises NMI and second maskable factor.
// - A write to clear port drops indicator and both interrupt factors; a same-clock time-over wins.
// - Software selects normal mode or page mode; behaviour follows it.
// - Page mode same-row accesses keep row strobe low, toggle columns.
// - Page mode row miss: row strobe high, wait precharge, reassert.
// - Row-match signal compares current row with the row kept from the last page mode cycle.
// - Four active-low column strobes, one per byte lane, only selected.
// - Normal mode read is single cycle; next waits for precharge.
// - Normal mode write is single cycle; next stalled via wait.
// - Software sets precharge, row low width and read column width.
// - Write column strobe low exactly one clock unless lengthened.
// - Row width exceeding read width by two or more: first read uses row-1.
// - Row width of two or more: first write uses row-1.
// - Same-row page access needs at least one fewer wait state.
`default_nettype none
package dpc_pkg;
    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] DPC_CTRL_OFS = 8'h00;
    localparam logic [7:0] DPC_STAT_OFS = 8'h04;
    localparam logic [7:0] DPC_CLR_OFS = 8'h08;
    // Control fields
    localparam int DPC_MODE_BIT = 0;
    localparam int DPC_XCLK_LSB = 4;
    localparam int DPC_YCLK_LSB = 8;
    localparam int DPC_ZCLK_LSB = 12;
    localparam int DPC_CNT_W = 4;
    // Status fields
    localparam int DPC_ST_OVER_BIT = 0;
    localparam int DPC_ST_NMI_BIT = 1;
    localparam int DPC_ST_IRQ2_BIT = 2;
    localparam int DPC_ST_HIT_BIT = 3;
    localparam int DPC_ST_RVAL_BIT = 4;
    // Reset values
    localparam logic DPC_MODE_RST = 1'b0;
    localparam logic [3:0] DPC_XCLK_RST = 4'h2;
    localparam logic [3:0] DPC_YCLK_RST = 4'h3;
    localparam logic [3:0] DPC_ZCLK_RST = 4'h2;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int DPC_TOUT_CLKS = 1024;
    localparam int DPC_TOUT_W = 10;
    localparam int DPC_ROW_W = 12;
    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        DPC_ST_IDLE = 3'b000,
        DPC_ST_PRE = 3'b001,
        DPC_ST_ACT = 3'b010,
        DPC_ST_CAS = 3'b011,
        DPC_ST_END = 3'b100
    } dpc_state_t;
endpackage
`default_nettype wire

// >>> hdl/dpc_dram_ctrl.sv
// DRAM page controller with external bus watchdog and APB registers.
// Assumes CPU bus signals come from logic clocked by pclk (no synchroniser).
//
// Register access over APB and the address map were decided locally.
`default_nettype none
module dpc_dram_ctrl
    import dpc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cpu_bus_active,
    input wire logic cpu_dram_sel,
    input wire logic cpu_dstb_n,
    input wire logic cpu_wr,
    input wire logic [3:0] cpu_be,
    input wire logic [DPC_ROW_W-1:0] cpu_row,
    output logic cpu_wait_n,
    output logic timeout_ready,
    output logic row_hit,
    output logic ras_n,
    output logic [3:0] byte_col_strobe_n,
    output logic dram_we_n,
    output logic overtime_indicator,
    output logic nmi_req,
    output logic maskable_irq_second
);
    // ****************************************************************
    // Register bus
    // ****************************************************************
    logic page_mode_r;
    logic [3:0] xclk_r;
    logic [3:0] yclk_r;
    logic [3:0] zclk_r;
    logic apb_wr;
    logic ctrl_wr;
    logic clr_wr;
    logic mapped;
    logic mode_chg;

    // Zero-wait slave; unmapped offsets answer with an error
    assign apb_wr = psel && penable && pwrite;
    assign mapped = (paddr == DPC_CTRL_OFS) || (paddr == DPC_STAT_OFS) ||
                    (paddr == DPC_CLR_OFS);
    assign ctrl_wr = apb_wr && (paddr == DPC_CTRL_OFS);
    assign clr_wr = apb_wr && (paddr == DPC_CLR_OFS);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign mode_chg = ctrl_wr && (pwdata[DPC_MODE_BIT] != page_mode_r);

    // Control register holds mode and the three strobe counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_mode_r <= DPC_MODE_RST;
            xclk_r <= DPC_XCLK_RST;
            yclk_r <= DPC_YCLK_RST;
            zclk_r <= DPC_ZCLK_RST;
        end else if (ctrl_wr) begin
            page_mode_r <= pwdata[DPC_MODE_BIT];
            xclk_r <= pwdata[DPC_XCLK_LSB +: DPC_CNT_W];
            yclk_r <= pwdata[DPC_YCLK_LSB +: DPC_CNT_W];
            zclk_r <= pwdata[DPC_ZCLK_LSB +: DPC_CNT_W];
        end
    end

    // ****************************************************************
    // Bus time-over watchdog
    // ****************************************************************
    logic [DPC_TOUT_W-1:0] tout_cnt_r;
    logic force_rdy;
    logic over_r;
    logic nmi_r;
    logic irq2_r;

    // Counter restarts whenever the CPU ends its cycle on its own
    assign force_rdy = cpu_bus_active &&
        (tout_cnt_r == DPC_TOUT_W'(DPC_TOUT_CLKS - 1));
    assign timeout_ready = force_rdy;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tout_cnt_r <= '0;
        end else if (!cpu_bus_active || force_rdy) begin
            tout_cnt_r <= '0;
        end else begin
            tout_cnt_r <= tout_cnt_r + 1'b1;
        end
    end

    // Sticky factors; a new time-over wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            over_r <= 1'b0;
            nmi_r <= 1'b0;
            irq2_r <= 1'b0;
        end else if (force_rdy) begin
            over_r <= 1'b1;
            nmi_r <= 1'b1;
            irq2_r <= 1'b1;
        end else if (clr_wr) begin
            over_r <= 1'b0;
            nmi_r <= 1'b0;
            irq2_r <= 1'b0;
        end
    end

    assign overtime_indicator = over_r;
    assign nmi_req = nmi_r;
    assign maskable_irq_second = irq2_r;

    // ****************************************************************
    // DRAM sequencer
    // ****************************************************************
    dpc_state_t state_r;
    logic [DPC_ROW_W-1:0] last_row_r;
    logic row_valid_r;
    logic done_r;
    logic first_r;
    logic [3:0] pre_cnt_r;
    logic [3:0] cas_cnt_r;
    logic [3:0] cas_w;
    logic [3:0] be_r;
    logic wr_r;
    logic ras_n_r;
    logic dram_req;
    logic hit;
    logic y_ge2;
    logic y_gt_z1;
    logic first_act;

    // Request is a DRAM data strobe not yet answered
    assign dram_req = cpu_dram_sel && !cpu_dstb_n && !done_r;
    assign hit = row_valid_r && (cpu_row == last_row_r);
    assign row_hit = hit;

    // Column width: reads use Z, writes one clock, row width may stretch
    assign y_ge2 = (yclk_r >= 4'h2);
    assign y_gt_z1 = ({1'b0, yclk_r} >= ({1'b0, zclk_r} + 5'h02));
    // Width is loaded in the activate state, so that is the first access
    assign first_act = (state_r == DPC_ST_ACT);
    always_comb begin
        if (cpu_wr) begin
            cas_w = (first_act && y_ge2) ? yclk_r - 4'h1 :
                    4'h1;
        end else if (first_act && y_gt_z1) begin
            cas_w = yclk_r - 4'h1;
        end else begin
            cas_w = (zclk_r == 4'h0) ? 4'h1 : zclk_r;
        end
    end

    // Stall the CPU until the end state answers; time-over frees it too
    assign cpu_wait_n = !(dram_req && (state_r != DPC_ST_END) &&
                          !force_rdy);

    // Main sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= DPC_ST_IDLE;
        end else if (force_rdy) begin
            state_r <= DPC_ST_IDLE;
        end else begin
            unique case (state_r)
                DPC_ST_IDLE: begin
                    if (dram_req) begin
                        if (page_mode_r && hit && !ras_n_r) begin
                            state_r <= DPC_ST_CAS;
                        end else if (!ras_n_r || pre_cnt_r != 4'h0) begin
                            state_r <= DPC_ST_PRE;
                        end else begin
                            state_r <= DPC_ST_ACT;
                        end
                    end
                end
                DPC_ST_PRE: begin
                    if (pre_cnt_r <= 4'h1 && ras_n_r) begin
                        state_r <= DPC_ST_ACT;
                    end
                end
                DPC_ST_ACT: state_r <= DPC_ST_CAS;
                DPC_ST_CAS: begin
                    if (cas_cnt_r == 4'h1) begin
                        state_r <= DPC_ST_END;
                    end
                end
                DPC_ST_END: state_r <= DPC_ST_IDLE;
                default: state_r <= DPC_ST_IDLE;
            endcase
        end
    end

    // Row strobe and precharge counter; normal mode closes the row
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ras_n_r <= 1'b1;
            pre_cnt_r <= '0;
        end else if (force_rdy || mode_chg ||
                     (state_r == DPC_ST_END && !page_mode_r) ||
                     (state_r == DPC_ST_IDLE && dram_req && !ras_n_r &&
                      !(page_mode_r && hit))) begin
            ras_n_r <= 1'b1;
            pre_cnt_r <= xclk_r;
        end else begin
            if (state_r == DPC_ST_ACT) begin
                ras_n_r <= 1'b0;
            end
            if (pre_cnt_r != 4'h0) begin
                pre_cnt_r <= pre_cnt_r - 4'h1;
            end
        end
    end

    // Column counter and latched lane/direction for the access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cas_cnt_r <= '0;
            be_r <= '0;
            wr_r <= 1'b0;
        end else if ((state_r == DPC_ST_ACT) ||
                     (state_r == DPC_ST_IDLE && dram_req)) begin
            cas_cnt_r <= cas_w;
            be_r <= cpu_be;
            wr_r <= cpu_wr;
        end else if (state_r == DPC_ST_CAS && cas_cnt_r != 4'h0) begin
            cas_cnt_r <= cas_cnt_r - 4'h1;
        end
    end

    // Flag set in the precharge state, cleared at the end state; only the c_miss cover reads it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_r <= 1'b0;
        end else if (state_r == DPC_ST_PRE) begin
            first_r <= 1'b1;
        end else if (state_r == DPC_ST_END) begin
            first_r <= 1'b0;
        end
    end

    // Remembered row; invalid after reset, mode change or forced end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            row_valid_r <= 1'b0;
            last_row_r <= '0;
        end else if (mode_chg || force_rdy) begin
            row_valid_r <= 1'b0;
        end else if (state_r == DPC_ST_END) begin
            row_valid_r <= page_mode_r;
            last_row_r <= cpu_row;
        end
    end

    // Answered flag holds off a re-start until the strobe is released
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_r <= 1'b0;
        end else if (state_r == DPC_ST_END || force_rdy) begin
            done_r <= 1'b1;
        end else if (cpu_dstb_n) begin
            done_r <= 1'b0;
        end
    end

    assign ras_n = ras_n_r;
    assign byte_col_strobe_n = (state_r == DPC_ST_CAS) ? ~be_r : 4'hF;
    assign dram_we_n = !((state_r == DPC_ST_CAS) && wr_r);

    // Status readback shows live factors and row tracking
    always_comb begin
        prdata = 32'h0000_0000;
        if (psel && !pwrite && paddr == DPC_CTRL_OFS) begin
            prdata[DPC_MODE_BIT] = page_mode_r;
            prdata[DPC_XCLK_LSB +: DPC_CNT_W] = xclk_r;
            prdata[DPC_YCLK_LSB +: DPC_CNT_W] = yclk_r;
            prdata[DPC_ZCLK_LSB +: DPC_CNT_W] = zclk_r;
        end else if (psel && !pwrite && paddr == DPC_STAT_OFS) begin
            prdata[DPC_ST_OVER_BIT] = over_r;
            prdata[DPC_ST_NMI_BIT] = nmi_r;
            prdata[DPC_ST_IRQ2_BIT] = irq2_r;
            prdata[DPC_ST_HIT_BIT] = hit;
            prdata[DPC_ST_RVAL_BIT] = row_valid_r;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_tout_force;
        @(posedge pclk) disable iff (!presetn)
        (cpu_bus_active && tout_cnt_r == 10'h3FE) ##1 cpu_bus_active
        |-> timeout_ready;
    endproperty
    a_tout_force: assert property (p_tout_force)
        else $error("watchdog did not fire at 1024 clocks");

    property p_force_flags;
        @(posedge pclk) disable iff (!presetn)
        force_rdy |=> (overtime_indicator && nmi_req && maskable_irq_second);
    endproperty
    a_force_flags: assert property (p_force_flags)
        else $error("time-over did not raise indicator and factors");

    property p_clear;
        @(posedge pclk) disable iff (!presetn)
        (clr_wr && !force_rdy) |=> !(overtime_indicator || nmi_req ||
                                 maskable_irq_second);
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear port left a factor set");

    property p_page_hit_ras;
        @(posedge pclk) disable iff (!presetn)
        (state_r == DPC_ST_IDLE && dram_req && page_mode_r && hit &&
         !ras_n && !force_rdy && !mode_chg) |=>
        (!ras_n && state_r == DPC_ST_CAS);
    endproperty
    a_page_hit_ras: assert property (p_page_hit_ras)
        else $error("same-row page access dropped row strobe");

    property p_miss_pre;
        @(posedge pclk) disable iff (!presetn)
        (state_r == DPC_ST_IDLE && dram_req && !ras_n && !hit && !force_rdy)
        |=> (ras_n && state_r == DPC_ST_PRE);
    endproperty
    a_miss_pre: assert property (p_miss_pre)
        else $error("row miss did not precharge");

    property p_lanes;
        @(posedge pclk) disable iff (!presetn)
        (state_r == DPC_ST_CAS) |-> (byte_col_strobe_n == ~be_r);
    endproperty
    a_lanes: assert property (p_lanes)
        else $error("column strobes differ from selected lanes");

    property p_normal_close;
        @(posedge pclk) disable iff (!presetn)
        (state_r == DPC_ST_END && !page_mode_r) |=> ras_n;
    endproperty
    a_normal_close: assert property (p_normal_close)
        else $error("normal mode kept row open");

    property p_wr_one;
        @(posedge pclk) disable iff (!presetn)
        (state_r == DPC_ST_ACT && cpu_wr && !y_ge2 && !force_rdy)
        |=> (state_r == DPC_ST_CAS) ##1 (state_r == DPC_ST_END);
    endproperty
    a_wr_one: assert property (p_wr_one)
        else $error("write column strobe not one clock");

    property p_row_inval;
        @(posedge pclk) disable iff (!presetn)
        mode_chg |=> !row_valid_r;
    endproperty
    a_row_inval: assert property (p_row_inval)
        else $error("mode change kept remembered row");

    c_force: cover property (@(posedge pclk) disable iff (!presetn) force_rdy);
    c_hit: cover property (@(posedge pclk) disable iff (!presetn)
        state_r == DPC_ST_IDLE ##1 state_r == DPC_ST_CAS);
    c_miss: cover property (@(posedge pclk) disable iff (!presetn)
        page_mode_r && state_r == DPC_ST_PRE && !first_r);
endmodule
`default_nettype wire

// >>> verif/dpc_dram_model.sv
// Behavioural DRAM module seen from its strobe pins.
// Assumes strobes change only on pclk edges; it measures, never answers.
`default_nettype none
module dpc_dram_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ras_n,
    input wire logic [3:0] byte_col_strobe_n,
    input wire logic dram_we_n,
    output logic [7:0] cas_w,
    output logic [3:0] lanes,
    output logic we_seen,
    output logic [15:0] pre_w,
    output logic [7:0] ras_falls
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // Strobe width capture
    // ****************************************************************
    logic [7:0] run_r;
    logic [3:0] acc_r;
    logic wacc_r;
    logic [15:0] hi_r;
    // Widths are kept until the next pulse so the bench can read late
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {run_r, acc_r, wacc_r, cas_w, lanes, we_seen} <= '0;
            {hi_r, pre_w, ras_falls} <= '0;
        end else begin
            if (byte_col_strobe_n != 4'hF) begin
                run_r <= run_r + 8'h01;
                acc_r <= acc_r | ~byte_col_strobe_n;
                wacc_r <= ~dram_we_n;
            end else if (run_r != 8'h00) begin
                cas_w <= run_r;
                lanes <= acc_r;
                we_seen <= wacc_r;
                run_r <= 8'h00;
                acc_r <= 4'h0;
            end
            // Precharge span is the high time before each activation
            if (ras_n) begin
                hi_r <= hi_r + 16'h0001;
            end else if (hi_r != 16'h0000) begin
                pre_w <= hi_r;
                ras_falls <= ras_falls + 8'h01;
                hi_r <= 16'h0000;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verif/dram_page_controller_with_bus_timeout_tb.sv
// Self-checking bench for the DRAM page controller and bus watchdog.
// Assumes the strobe monitor model and one 40 MHz clock.
`default_nettype none
`define CHK(g, e) begin \
    compares++; \
    if ((g) !== (e)) begin \
        fail_count++; \
        $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); \
    end \
end
module dram_page_controller_with_bus_timeout_tb;
    import dpc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // Signals and helpers
    // ****************************************************************
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'hB5F8843B;
    logic pready, pslverr, cpu_bus_active = 0, cpu_dram_sel = 0;
    logic cpu_dstb_n = 1, cpu_wr = 0, cpu_wait_n, timeout_ready, row_hit;
    logic [3:0] cpu_be = 4'h0, byte_col_strobe_n, lanes;
    logic [DPC_ROW_W-1:0] cpu_row = '0;
    logic ras_n, dram_we_n, overtime_indicator, nmi_req;
    logic maskable_irq_second, we_seen;
    logic [7:0] cas_w, ras_falls;
    logic [15:0] pre_w;
    int fail_count = 0, compares = 0;
    always #12.5 pclk = ~pclk;
    dpc_dram_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpu_bus_active(cpu_bus_active),
        .cpu_dram_sel(cpu_dram_sel), .cpu_dstb_n(cpu_dstb_n),
        .cpu_wr(cpu_wr), .cpu_be(cpu_be), .cpu_row(cpu_row),
        .cpu_wait_n(cpu_wait_n), .timeout_ready(timeout_ready),
        .row_hit(row_hit), .ras_n(ras_n),
        .byte_col_strobe_n(byte_col_strobe_n), .dram_we_n(dram_we_n),
        .overtime_indicator(overtime_indicator), .nmi_req(nmi_req),
        .maskable_irq_second(maskable_irq_second));
    dpc_dram_model mem (.pclk(pclk), .presetn(presetn), .ras_n(ras_n),
        .byte_col_strobe_n(byte_col_strobe_n), .dram_we_n(dram_we_n),
        .cas_w(cas_w), .lanes(lanes), .we_seen(we_seen), .pre_w(pre_w),
        .ras_falls(ras_falls));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Expected column width; only the first access after activation stretches
    function automatic int cas_exp(logic w, int y, int z, bit first);
        if (w) return (first && y >= 2) ? y - 1 : 1;
        if (first && y >= z + 2) return y - 1;
        return (z == 0) ? 1 : z;
    endfunction
    task automatic test_done();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ****************************************************************
    // Bus tasks, entered just after a rising edge
    // ****************************************************************
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        if (n >= 50) fail_count++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // One DRAM cycle: strobe held through the end state, released at the edge that leaves it
    task automatic acc(input logic w, input logic [11:0] row,
                       input logic chkh, input logic exph, input int ew,
                       output int waits);
        logic [3:0] be;
        be = 4'(rnd() % 15 + 1);
        waits = 0;
        cpu_bus_active <= 1'b1;
        cpu_dram_sel <= 1'b1;
        cpu_dstb_n <= 1'b0;
        cpu_wr <= w;
        cpu_be <= be;
        cpu_row <= row;
        @(negedge pclk);
        if (chkh) `CHK(row_hit, exph)
        @(posedge pclk);
        // Wait line is read mid-cycle, away from the edge that launches it
        @(negedge pclk);
        while (cpu_wait_n !== 1'b1 && waits < 100) begin
            @(negedge pclk);
            waits++;
        end
        if (waits >= 100) fail_count++;
        @(posedge pclk);
        cpu_bus_active <= 1'b0;
        cpu_dram_sel <= 1'b0;
        cpu_dstb_n <= 1'b1;
        repeat (4) @(posedge pclk);
        `CHK(lanes, be)
        `CHK(we_seen, w)
        `CHK(cas_w, 8'(ew))
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    logic [11:0] tab [6] = '{12'h032, 12'h052, 12'h013, 12'h112,
                             12'h142, 12'h020};
    initial begin
        #1000000;
        fail_count++;
        test_done();
    end
    initial begin
        logic [31:0] q;
        logic e;
        logic [11:0] r;
        logic [7:0] rf;
        int wt, wn, wh, n;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, DPC_CTRL_OFS, 0, q, e);
        `CHK(q, 32'h00002320)
        apb(0, 8'h0C, 0, q, e);
        `CHK({e, q}, 33'h100000000)
        // Normal mode sweep over row and column widths
        foreach (tab[i]) begin
            apb(1, DPC_CTRL_OFS, {16'h0, tab[i][3:0], tab[i][7:4], 8'h20},
                q, e);
            acc(tab[i][8], 12'(rnd()), 0, 0,
                cas_exp(tab[i][8], tab[i][7:4], tab[i][3:0], 1), wt);
            if (i == 0) wn = wt;
            if (i > 0) `CHK(pre_w >= 2, 1'b1)
        end
        // Long precharge must stall the next access
        apb(1, DPC_CTRL_OFS, 32'h000023F0, q, e);
        acc(0, 12'(rnd()), 0, 0, 2, wt);
        acc(1, 12'(rnd()), 0, 0, 2, wt);
        `CHK(pre_w >= 15, 1'b1)
        `CHK(wt > wn, 1'b1)
        // Page mode: miss, hits, then a different row
        apb(1, DPC_CTRL_OFS, 32'h00002331, q, e);
        r = 12'(rnd());
        acc(0, r, 1, 0, 2, wt);
        rf = ras_falls;
        acc(0, r, 1, 1, 2, wh);
        `CHK(wh < wn, 1'b1)
        acc(1, r, 1, 1, 1, wt);
        `CHK(ras_falls, rf)
        apb(0, DPC_STAT_OFS, 0, q, e);
        `CHK(q[DPC_ST_RVAL_BIT], 1'b1)
        acc(0, r ^ 12'h001, 1, 0, 2, wt);
        `CHK(ras_falls, 8'(rf + 1))
        `CHK(pre_w >= 3, 1'b1)
        apb(1, DPC_CTRL_OFS, 32'h00002330, q, e);
        apb(1, DPC_CTRL_OFS, 32'h00002331, q, e);
        acc(0, r ^ 12'h001, 1, 0, 2, wt);
        // Watchdog: a bus cycle that never ends
        cpu_bus_active <= 1'b1;
        n = 0;
        while (n < 1100) begin
            @(negedge pclk);
            n++;
            if (timeout_ready === 1'b1) break;
        end
        `CHK(n >= 1023 && n <= 1025, 1'b1)
        @(posedge pclk);
        cpu_bus_active <= 1'b0;
        @(posedge pclk);
        @(negedge pclk);
        `CHK({overtime_indicator, nmi_req, maskable_irq_second}, 3'h7)
        @(posedge pclk);
        apb(0, DPC_STAT_OFS, 0, q, e);
        `CHK(q[2:0], 3'h7)
        apb(1, DPC_CLR_OFS, rnd(), q, e);
        @(negedge pclk);
        `CHK({overtime_indicator, nmi_req, maskable_irq_second}, 3'h0)
        @(posedge pclk);
        apb(0, DPC_STAT_OFS, 0, q, e);
        `CHK(q[2:0], 3'h0)
        test_done();
    end
endmodule
`default_nettype wire
